// ---- src/ppd_pkg.sv ----
// Constants and types shared by the processor port display multiplexer.
// Assumes one clock domain and pins synchronous to it.
package ppd_pkg;

    localparam int SEL_W = 5;
    localparam int DATA_W = 8;
    localparam int REG_COUNT = 32;
    localparam int NUM_PORTS = 13;
    localparam int CFG_W = SEL_W + DATA_W;
    localparam logic [4:0] EVT_REC_ADDR = 5'h10;
    localparam logic [4:0] EVT_MASK_ADDR = 5'h11;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'hff;
    localparam logic [12:0] CFG_RST = 13'h0000;
    localparam int CFG_MAX_BIT = 0;
    localparam logic [3:0] PORT_DEV = 4'h0;
    localparam logic [3:0] PORT_FIRST = 4'h1;
    localparam logic [3:0] PORT_HI_FIRST = 4'h8;
    localparam logic [3:0] PORT_LAST = 4'hd;

    typedef enum logic [3:0] {
        SQ_ADDR = 4'b0001,
        SQ_DATA = 4'b0010,
        SQ_STROBE = 4'b0100,
        SQ_HOLD = 4'b1000
    } ppd_seq_state_t;

    typedef enum logic [4:0] {
        AC_IDLE = 5'b00001,
        AC_WAIT = 5'b00010,
        AC_DRIVE = 5'b00100,
        AC_READY = 5'b01000,
        AC_LOAD = 5'b10000
    } ppd_acc_state_t;

endpackage

// ---- src/ppd_disp_if.sv ----
// Link between the access controller and the display sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface ppd_disp_if;
    logic hold;
    logic restart;
    logic max_mode;
    logic [103:0] port_data;
    logic [7:0] dev_data;
    logic [7:0] data;
    logic strobe_lo_n;
    logic strobe_hi_n;
    logic busy;

    modport seq (
        input hold, restart, max_mode, port_data, dev_data,
        output data, strobe_lo_n, strobe_hi_n, busy
    );
    modport ctl (
        output hold, restart, max_mode, port_data, dev_data,
        input data, strobe_lo_n, strobe_hi_n, busy
    );
endinterface

// ---- src/ppd_disp_seq.sv ----
// Display sequencer: walks the ports, puts address then data out and
// pulses the matching strobe. Assumes the controller raises hold for
// any access and only turns the pins around while busy is low, except for a configuration load.
`timescale 1ns/1ps
module ppd_disp_seq (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Controller side
    ppd_disp_if.seq d
);
    ppd_pkg::ppd_seq_state_t st_r, st_nxt;
    logic [3:0] port_r, port_nxt;
    logic [7:0] data_r, data_nxt;
    logic lo_r, lo_nxt;
    logic hi_r, hi_nxt;
    logic [3:0] pi;
    logic [7:0] word;
    logic use_hi;

    always_comb begin
        pi = (port_r == ppd_pkg::PORT_DEV) ? ppd_pkg::PORT_FIRST : port_r;
        word = d.max_mode ? d.port_data[8*(int'(pi)-1) +: 8]
                          : d.dev_data;
        use_hi = d.max_mode && (port_r >= ppd_pkg::PORT_HI_FIRST);
        st_nxt = st_r;
        port_nxt = port_r;
        data_nxt = data_r;
        lo_nxt = 1'b1;
        hi_nxt = 1'b1;
        case (st_r)
            ppd_pkg::SQ_ADDR: begin
                data_nxt = {4'h0, port_r};
                // A restart under the old mode may leave the device slot.
                if (d.max_mode && port_r == ppd_pkg::PORT_DEV) begin
                    port_nxt = ppd_pkg::PORT_FIRST;
                end else if (!d.hold) begin
                    st_nxt = ppd_pkg::SQ_DATA;
                end
            end
            ppd_pkg::SQ_DATA: begin
                data_nxt = word;
                if (d.hold) begin
                    st_nxt = ppd_pkg::SQ_ADDR;
                end else begin
                    st_nxt = ppd_pkg::SQ_STROBE;
                    lo_nxt = use_hi;
                    hi_nxt = !use_hi;
                end
            end
            ppd_pkg::SQ_STROBE: begin
                st_nxt = ppd_pkg::SQ_HOLD;
            end
            ppd_pkg::SQ_HOLD: begin
                st_nxt = ppd_pkg::SQ_ADDR;
                if (!d.max_mode) begin
                    port_nxt = ppd_pkg::PORT_DEV;
                end else if (port_r >= ppd_pkg::PORT_LAST) begin
                    port_nxt = ppd_pkg::PORT_FIRST;
                end else begin
                    port_nxt = port_r + 4'h1;
                end
            end
            default: begin
                st_nxt = ppd_pkg::SQ_ADDR;
            end
        endcase
        // A pulse in flight still gets its hold cycle before a restart.
        if (d.restart && st_r != ppd_pkg::SQ_STROBE) begin
            st_nxt = ppd_pkg::SQ_ADDR;
            port_nxt = d.max_mode ? ppd_pkg::PORT_FIRST : ppd_pkg::PORT_DEV;
            lo_nxt = 1'b1;
            hi_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= ppd_pkg::SQ_ADDR;
            port_r <= ppd_pkg::PORT_DEV;
            data_r <= 8'h00;
            lo_r <= 1'b1;
            hi_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            port_r <= port_nxt;
            data_r <= data_nxt;
            lo_r <= lo_nxt;
            hi_r <= hi_nxt;
        end
    end

    assign d.data = data_r;
    assign d.strobe_lo_n = lo_r;
    assign d.strobe_hi_n = hi_r;
    // A started pulse and its hold cycle always run to the end.
    assign d.busy = (st_r == ppd_pkg::SQ_STROBE) || (st_r == ppd_pkg::SQ_HOLD);

    a_pulse_finish: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (st_r == ppd_pkg::SQ_STROBE) |=> (st_r == ppd_pkg::SQ_HOLD)
            && (data_r == $past(data_r)))
        else $error("strobe pulse not followed by hold");
    a_min_hi_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (!d.max_mode && !d.restart) |=> hi_r)
        else $error("high strobe pulsed in minimum mode");
    a_lo_port_range: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (!lo_r && $past(d.max_mode)) |-> (port_r >= ppd_pkg::PORT_FIRST)
            && (port_r < ppd_pkg::PORT_HI_FIRST))
        else $error("low strobe on wrong port");
    c_hi_strobe: cover property (@(posedge clk_sys) disable iff (!arst_n)
        !hi_r);
endmodule

// ---- src/ppd_port.sv ----
// Processor port with display multiplexing: shared pins carry display
// traffic while idle and register accesses while a strobe is low.
// Assumes pins are synchronous to clk_sys and the select lines are
// always driven to a valid level.
`timescale 1ns/1ps
module ppd_port (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Processor strobes and select
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic config_load_n,
    input wire logic [4:0] reg_select,
    // Shared data pins
    input wire logic [7:0] shared_bus_pins_in,
    output logic [7:0] shared_bus_pins_out,
    output logic shared_bus_pins_oe,
    // Display latches, transceiver and processor ready
    output logic display_strobe_lo_n,
    output logic display_strobe_hi_n,
    output logic transceiver_enable_n,
    output logic rdy,
    // Hub management side
    input wire logic [103:0] disp_port_data,
    input wire logic [7:0] disp_dev_data,
    input wire logic [7:0] event_in,
    output logic event_log_irq_n,
    output logic [12:0] config_word
);
    ppd_disp_if d ();

    ppd_disp_seq u_seq (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .d(d)
    );

    ppd_pkg::ppd_acc_state_t ac_r, ac_nxt;
    logic [7:0] regs_r [0:ppd_pkg::REG_COUNT-1];
    logic [4:0] sel_r, sel_nxt;
    logic is_rd_r, is_rd_nxt;
    logic [7:0] pend_r, pend_nxt;
    logic [12:0] cfg_r, cfg_nxt;
    logic load_prev_r;
    logic [7:0] bus_out_r, bus_out_nxt;
    logic oe_r, oe_nxt;
    logic lo_r, lo_nxt;
    logic hi_r, hi_nxt;
    logic xen_r, xen_nxt;
    logic rdy_r, rdy_nxt;
    logic irq_r, irq_nxt;
    logic acc_req, do_acc, wr_en, load_rise, clr;
    logic [7:0] rd_word;
    logic [7:0] mask;
    logic [7:0] mask_nxt;

    assign acc_req = !rd_n || !wr_n;
    assign load_rise = !load_prev_r && config_load_n;
    assign mask = regs_r[ppd_pkg::EVT_MASK_ADDR];
    assign d.hold = acc_req || !config_load_n;
    assign d.restart = (ac_r == ppd_pkg::AC_LOAD);
    assign d.max_mode = cfg_r[ppd_pkg::CFG_MAX_BIT];
    assign d.port_data = disp_port_data;
    assign d.dev_data = disp_dev_data;

    always_comb begin
        ac_nxt = ac_r;
        sel_nxt = sel_r;
        is_rd_nxt = is_rd_r;
        do_acc = 1'b0;
        case (ac_r)
            ppd_pkg::AC_IDLE: begin
                if (acc_req) begin
                    ac_nxt = ppd_pkg::AC_WAIT;
                    // Select is sampled only once a strobe is low.
                    sel_nxt = reg_select;
                    is_rd_nxt = !rd_n;
                end
            end
            ppd_pkg::AC_WAIT: begin
                if (!acc_req) begin
                    ac_nxt = ppd_pkg::AC_IDLE;
                end else if (!d.busy) begin
                    ac_nxt = ppd_pkg::AC_DRIVE;
                end
            end
            ppd_pkg::AC_DRIVE: begin
                ac_nxt = ppd_pkg::AC_READY;
                do_acc = 1'b1;
            end
            ppd_pkg::AC_READY: begin
                if (!acc_req) begin
                    ac_nxt = ppd_pkg::AC_IDLE;
                end
            end
            ppd_pkg::AC_LOAD: begin
                if (config_load_n) begin
                    ac_nxt = ppd_pkg::AC_IDLE;
                end
            end
            default: begin
                ac_nxt = ppd_pkg::AC_IDLE;
            end
        endcase
        if (!config_load_n) begin
            ac_nxt = ppd_pkg::AC_LOAD;
        end
    end

    always_comb begin
        rd_word = (sel_r == ppd_pkg::EVT_REC_ADDR) ? pend_r
                                                   : regs_r[sel_r];
        wr_en = do_acc && !is_rd_r
            && (sel_r != ppd_pkg::EVT_REC_ADDR);
        clr = do_acc && (sel_r == ppd_pkg::EVT_REC_ADDR);
        // A new event in the clearing cycle survives the clear.
        pend_nxt = (pend_r & ~(clr ? 8'hff : 8'h00)) | event_in;
        cfg_nxt = cfg_r;
        if (load_rise) begin
            cfg_nxt = {reg_select, shared_bus_pins_in};
            pend_nxt = 8'h00;
        end
        // The mask written in this cycle already governs the next level.
        mask_nxt = (wr_en && sel_r == ppd_pkg::EVT_MASK_ADDR)
            ? shared_bus_pins_in : mask;
        irq_nxt = ~|(pend_nxt & ~mask_nxt);
    end

    always_comb begin
        bus_out_nxt = d.data;
        oe_nxt = 1'b1;
        xen_nxt = 1'b1;
        rdy_nxt = 1'b1;
        lo_nxt = d.hold ? 1'b1 : d.strobe_lo_n;
        hi_nxt = d.hold ? 1'b1 : d.strobe_hi_n;
        case (ac_nxt)
            ppd_pkg::AC_DRIVE: begin
                bus_out_nxt = rd_word;
                oe_nxt = is_rd_r;
                xen_nxt = 1'b0;
            end
            ppd_pkg::AC_READY: begin
                bus_out_nxt = bus_out_r;
                oe_nxt = is_rd_r;
                xen_nxt = 1'b0;
                rdy_nxt = 1'b0;
            end
            ppd_pkg::AC_LOAD: begin
                oe_nxt = 1'b0;
                xen_nxt = 1'b0;
            end
            default: begin
                bus_out_nxt = d.data;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ac_r <= ppd_pkg::AC_IDLE;
            sel_r <= 5'h00;
            is_rd_r <= 1'b0;
            pend_r <= 8'h00;
            cfg_r <= ppd_pkg::CFG_RST;
            load_prev_r <= 1'b1;
            bus_out_r <= 8'h00;
            oe_r <= 1'b1;
            lo_r <= 1'b1;
            hi_r <= 1'b1;
            xen_r <= 1'b1;
            rdy_r <= 1'b1;
            irq_r <= 1'b1;
            for (int i = 0; i < ppd_pkg::REG_COUNT; i++) begin
                regs_r[i] <= ppd_pkg::REG_RST;
            end
            regs_r[ppd_pkg::EVT_MASK_ADDR] <= ppd_pkg::MASK_RST;
        end else begin
            ac_r <= ac_nxt;
            sel_r <= sel_nxt;
            is_rd_r <= is_rd_nxt;
            pend_r <= pend_nxt;
            cfg_r <= cfg_nxt;
            load_prev_r <= config_load_n;
            bus_out_r <= bus_out_nxt;
            oe_r <= oe_nxt;
            lo_r <= lo_nxt;
            hi_r <= hi_nxt;
            xen_r <= xen_nxt;
            rdy_r <= rdy_nxt;
            irq_r <= irq_nxt;
            if (wr_en) begin
                regs_r[sel_r] <= shared_bus_pins_in;
            end
        end
    end

    assign shared_bus_pins_out = bus_out_r;
    assign shared_bus_pins_oe = oe_r;
    assign display_strobe_lo_n = lo_r;
    assign display_strobe_hi_n = hi_r;
    assign transceiver_enable_n = xen_r;
    assign rdy = rdy_r;
    assign event_log_irq_n = irq_r;
    assign config_word = cfg_r;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    a_strobe_quiet: assert property (
        (ac_r == ppd_pkg::AC_DRIVE || ac_r == ppd_pkg::AC_READY)
            |-> display_strobe_lo_n && display_strobe_hi_n)
        else $error("display strobe active during access");
    a_xcvr_follow: assert property (
        (ac_r == ppd_pkg::AC_WAIT) ##1 (ac_r == ppd_pkg::AC_DRIVE)
            |-> !transceiver_enable_n && $past(transceiver_enable_n))
        else $error("transceiver enable wrong at turnaround");
    a_read_ready: assert property (
        (ac_r == ppd_pkg::AC_DRIVE && is_rd_r) |-> shared_bus_pins_oe
            ##1 !rdy && shared_bus_pins_oe
            && shared_bus_pins_out == $past(shared_bus_pins_out))
        else $error("read data not stable at ready fall");
    a_ready_return: assert property (
        (ac_r == ppd_pkg::AC_READY && rd_n && wr_n && config_load_n)
            |=> rdy)
        else $error("ready not returned high");
    a_irq_masked: assert property (
        ##1 (event_log_irq_n == ~|(pend_r & ~mask)))
        else $error("interrupt output disagrees with mask");
    a_clear_access: assert property (
        (clr && !load_rise) |=> pend_r == $past(event_in))
        else $error("event clear lost or incomplete");
    a_display_idle: assert property (
        (ac_r == ppd_pkg::AC_IDLE && $past(ac_r) == ppd_pkg::AC_IDLE)
            |-> shared_bus_pins_oe && transceiver_enable_n)
        else $error("pins not in display role while idle");
    a_write_store: assert property (
        (ac_r == ppd_pkg::AC_DRIVE && !is_rd_r
            && sel_r == ppd_pkg::EVT_MASK_ADDR)
            |=> mask == $past(shared_bus_pins_in) && !rdy)
        else $error("write data not stored before ready");
    a_cfg_capture: assert property (
        load_rise |=> config_word == $past({reg_select, shared_bus_pins_in})
            && pend_r == 8'h00)
        else $error("configuration not captured on load rise");
    c_read: cover property (ac_r == ppd_pkg::AC_READY && is_rd_r);
    c_write: cover property (ac_r == ppd_pkg::AC_READY && !is_rd_r);
    c_irq: cover property (!event_log_irq_n ##[1:20] event_log_irq_n);
endmodule

// ---- bench/ppd_latch_model.sv ----
// Partner model: host drivers on the shared pins and the display latches.
// Assumes the bench drives host_d and host_oe like the management CPU.
`timescale 1ns/1ps
module ppd_latch_model (
    // Clock
    input wire logic clk_sys,
    // Pin drivers
    input wire logic [7:0] pins_out,
    input wire logic pins_oe,
    input wire logic [7:0] host_d,
    input wire logic host_oe,
    output logic [7:0] bus,
    // Display strobes and latch contents
    input wire logic strobe_lo_n,
    input wire logic strobe_hi_n,
    output logic [7:0] lo_q,
    output logic [7:0] hi_q,
    output int lo_cnt,
    output int hi_cnt
);
    logic [7:0] last_r = 8'h00;

    // A released bus shows the inverse of its last level, never a hold.
    always_comb begin
        if (pins_oe)
            bus = pins_out;
        else if (host_oe)
            bus = host_d;
        else
            bus = ~last_r;
    end

    always @(posedge clk_sys) begin
        last_r <= bus;
    end

    initial begin
        lo_cnt = 0;
        hi_cnt = 0;
    end

    // Each latch takes the pins on the rising edge of its strobe.
    always @(posedge strobe_lo_n) begin
        lo_q <= bus;
        lo_cnt <= lo_cnt + 1;
    end

    always @(posedge strobe_hi_n) begin
        hi_q <= bus;
        hi_cnt <= hi_cnt + 1;
    end
endmodule

// ---- bench/processor_port_display_mux_tb.sv ----
// Self-checking bench for the processor port display multiplexer.
// Assumes ppd_port and the latch model; inputs change at falling edges.
`timescale 1ns/1ps
module processor_port_display_mux_tb;
    logic clk_sys, arst_n, rd_n, wr_n, config_load_n;
    logic [4:0] reg_select;
    logic [7:0] bus, pins_out, host_d, lo_q, hi_q, event_in, disp_dev_data;
    logic pins_oe, host_oe, display_strobe_lo_n, display_strobe_hi_n;
    logic transceiver_enable_n, rdy, event_log_irq_n;
    logic [103:0] disp_port_data;
    logic [12:0] config_word;
    logic [7:0] rv;
    int lo_cnt, hi_cnt, bad_count, total_checks, cycles;

    ppd_port DUT (
        .clk_sys(clk_sys), .arst_n(arst_n), .rd_n(rd_n), .wr_n(wr_n),
        .config_load_n(config_load_n), .reg_select(reg_select),
        .shared_bus_pins_in(bus), .shared_bus_pins_out(pins_out),
        .shared_bus_pins_oe(pins_oe),
        .display_strobe_lo_n(display_strobe_lo_n),
        .display_strobe_hi_n(display_strobe_hi_n),
        .transceiver_enable_n(transceiver_enable_n), .rdy(rdy),
        .disp_port_data(disp_port_data), .disp_dev_data(disp_dev_data),
        .event_in(event_in), .event_log_irq_n(event_log_irq_n),
        .config_word(config_word)
    );

    ppd_latch_model latches (
        .clk_sys(clk_sys), .pins_out(pins_out), .pins_oe(pins_oe),
        .host_d(host_d), .host_oe(host_oe), .bus(bus),
        .strobe_lo_n(display_strobe_lo_n), .strobe_hi_n(display_strobe_hi_n),
        .lo_q(lo_q), .hi_q(hi_q), .lo_cnt(lo_cnt), .hi_cnt(hi_cnt)
    );

    always #50 clk_sys = ~clk_sys;

    task automatic end_sim();
        if (bad_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("BAD %0t %s", $time, m);
        end
    endtask

    // The run should need well under a thousand cycles.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            end_sim();
        end
    end

    // One host access; write data stays on the pins until ready falls.
    task automatic acc(input logic wr, input logic [4:0] a,
                       input logic [7:0] wd, output logic [7:0] rd);
        int n;
        n = 0;
        @(negedge clk_sys);
        reg_select = a;
        host_d = wd;
        host_oe = wr;
        if (wr)
            wr_n = 1'b0;
        else
            rd_n = 1'b0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (rdy !== 1'b0 && n < 10);
        chk(n >= 3 && n <= 5, "ready latency");
        chk(transceiver_enable_n === 1'b0, "enable in access");
        chk(pins_oe === !wr, "pin direction");
        chk(display_strobe_lo_n === 1'b1, "lo strobe in access");
        chk(display_strobe_hi_n === 1'b1, "hi strobe in access");
        rd = bus;
        rd_n = 1'b1;
        wr_n = 1'b1;
        host_oe = 1'b0;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (rdy !== 1'b1 && n < 10);
        chk(n <= 2, "ready release");
        chk(transceiver_enable_n === 1'b1, "enable after access");
    endtask

    task automatic load_cfg(input logic [4:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        config_load_n = 1'b0;
        reg_select = a;
        host_d = d;
        host_oe = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk(transceiver_enable_n === 1'b0, "enable in load");
        config_load_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        host_oe = 1'b0;
        chk(config_word === {a, d}, "config capture");
    endtask

    task automatic t_regs();
        acc(1'b1, 5'h05, 8'ha5, rv);
        acc(1'b1, 5'h1f, 8'h3c, rv);
        acc(1'b0, 5'h1f, 8'h00, rv);
        chk(rv === 8'h3c, "read top reg");
        acc(1'b0, 5'h05, 8'h00, rv);
        chk(rv === 8'ha5, "read reg 5");
    endtask

    task automatic t_display(input logic max);
        int nl, nh, l0, h0;
        nl = lo_cnt;
        nh = hi_cnt;
        l0 = lo_cnt;
        h0 = hi_cnt;
        for (int i = 0; i < 160; i++) begin
            @(negedge clk_sys);
            chk(pins_oe === 1'b1, "display drive");
            chk(transceiver_enable_n === 1'b1, "display enable");
            if (lo_cnt != nl && max)
                chk(lo_q % 17 == 0 && lo_q / 17 inside {[1:7]}, "lo word");
            if (lo_cnt != nl && !max)
                chk(lo_q === 8'h5a, "device word");
            if (hi_cnt != nh)
                chk(max && hi_q % 17 == 0 && hi_q / 17 inside {[8:13]},
                    "hi word");
            nl = lo_cnt;
            nh = hi_cnt;
        end
        chk(lo_cnt > l0, "lo strobes seen");
        chk((hi_cnt > h0) === max, "hi strobe use");
    endtask

    task automatic pulse(input logic [7:0] m);
        @(negedge clk_sys);
        event_in = m;
        @(negedge clk_sys);
        event_in = 8'h00;
        repeat (2) @(negedge clk_sys);
    endtask

    task automatic t_events();
        acc(1'b1, 5'h11, 8'hfd, rv);
        pulse(8'h01);
        chk(event_log_irq_n === 1'b1, "masked source");
        pulse(8'h02);
        chk(event_log_irq_n === 1'b0, "unmasked source");
        acc(1'b0, 5'h10, 8'h00, rv);
        chk(rv[1] === 1'b1, "pending read");
        chk(event_log_irq_n === 1'b1, "cleared by access");
        acc(1'b0, 5'h11, 8'h00, rv);
        chk(rv === 8'hfd, "mask read");
    endtask

    initial begin
        clk_sys = 1'b0;
        arst_n = 1'b0;
        rd_n = 1'b1;
        wr_n = 1'b1;
        config_load_n = 1'b1;
        reg_select = 5'h00;
        host_d = 8'h00;
        host_oe = 1'b0;
        event_in = 8'h00;
        disp_dev_data = 8'h5a;
        bad_count = 0;
        total_checks = 0;
        cycles = 0;
        for (int p = 1; p <= 13; p++)
            disp_port_data[8*(p-1)+:8] = 8'(p * 17);
        repeat (3) @(negedge clk_sys);
        arst_n = 1'b1;
        @(negedge clk_sys);
        chk(rdy === 1'b1 && event_log_irq_n === 1'b1, "reset outputs");
        chk(config_word === 13'h0000, "reset config");
        load_cfg(5'h0a, 8'h01);
        t_regs();
        t_display(1'b1);
        t_events();
        load_cfg(5'h00, 8'h00);
        t_display(1'b0);
        end_sim();
    end
endmodule
